/* src/utlc_pkg.sv */
// Constants, register map and state type for the USB transmit endpoint
// and link power control block.
// Assumes a 10 MHz system clock and an APB master with 32-bit data.
package utlc_pkg;
   localparam int NUM_TX_EP = 7;
   localparam int NUM_RX_EP = 7;
   localparam int IDX_W     = 3;
   localparam int MAXP_W    = 11;
   localparam int MULT_W    = 5;
   localparam int ADDR_W    = 12;
   localparam int RES_W     = 14;

   localparam logic [ADDR_W-1:0] REG_INDEX   = 12'h000;
   localparam logic [ADDR_W-1:0] REG_EP_CTRL = 12'h004;
   localparam logic [ADDR_W-1:0] REG_LPM     = 12'h008;

   // Indexed transmit endpoint control word.
   localparam int B_AUTO   = 31;
   localparam int B_ISO    = 30;
   localparam int B_DIR    = 29;
   localparam int B_DMAEN  = 28;
   localparam int B_FRC    = 27;
   localparam int B_DMAMD  = 26;
   localparam int B_WEN    = 25;
   localparam int B_TOG    = 24;
   localparam int B_CLRTOG = 22;
   localparam int B_FIFO_NOT_EMPTY = 17;
   localparam int B_PKTRDY = 16;
   localparam int MULT_LSB = 11;
   localparam int MAXP_LSB = 0;

   // Link power control word.
   localparam int B_L1ST    = 22;
   localparam int B_NYETF   = 21;
   localparam int B_ACKF    = 20;
   localparam int LPM_ENABLE_FIELD_LSB = 17;
   localparam int B_L1REQ   = 16;
   localparam int LPMEP_LSB = 12;
   localparam int B_RWAKE   = 8;
   localparam int HOST_RESUME_DURATION_LSB  = 4;
   localparam logic [1:0] LPM_ENABLE_FIELD_L1 = 2'h3;
   localparam logic [1:0] TMO_LAST = 2'h2;

   // Resume timing.
   localparam int CLK_HZ      = 10000000;
   localparam int HZ_PER_MHZ  = 1000000;
   localparam int RES_BASE_US = 50;
   localparam int RES_STEP_US = 75;
   localparam int RES_MAX_US  = 1200;

   typedef struct packed {
      logic [IDX_W-1:0]                   index;
      logic [NUM_TX_EP-1:0]               auto_set;
      logic [NUM_TX_EP-1:0]               iso;
      logic [NUM_TX_EP-1:0]               dir_tx;
      logic [NUM_TX_EP-1:0]               dma_en;
      logic [NUM_TX_EP-1:0]               frc;
      logic [NUM_TX_EP-1:0]               dma_md;
      logic [NUM_TX_EP-1:0]               tog;
      logic [NUM_TX_EP-1:0]               pktrdy;
      logic [NUM_TX_EP-1:0]               fifo_clr;
      logic [NUM_TX_EP-1:0][MAXP_W-1:0]   maxp;
      logic [NUM_TX_EP-1:0][MULT_W-1:0]   mult;
      logic                               l1_req;
      logic [1:0]                         lpm_en;
      logic [3:0]                         lpm_ep;
      logic                               rwake;
      logic [3:0]                         host_resume_duration;
      logic                               l1_state;
      logic [1:0]                         tmo_cnt;
      logic                               ack_f;
      logic                               nyet_f;
      logic                               lpm_ack;
      logic                               lpm_nyet;
      logic                               lpm_evt;
      logic                               lpm_send;
      logic [RES_W-1:0]                   res_cnt;
      logic [31:0]                        prdata;
      logic                               pslverr;
   } utlc_state_t;
endpackage : utlc_pkg

/* src/utlc_ctrl.sv */
// Transmit endpoint control for endpoints one to seven and link power
// management request logic, with an APB register slave.
// Assumes the packet engine and FIFO controller run on clk_i, so their
// status and event pulses arrive synchronous and need no synchroniser.
`timescale 1ns/1ps
module utlc_ctrl #(
   parameter int RESUME_BASE_CYC =
      utlc_pkg::RES_BASE_US * (utlc_pkg::CLK_HZ / utlc_pkg::HZ_PER_MHZ),
   parameter int RESUME_STEP_CYC =
      utlc_pkg::RES_STEP_US * (utlc_pkg::CLK_HZ / utlc_pkg::HZ_PER_MHZ)
) (
   input  wire logic                            clk_i,
   input  wire logic                            rst_n_i,
   input  wire logic [utlc_pkg::ADDR_W-1:0]     paddr_i,
   input  wire logic                            psel_i,
   input  wire logic                            penable_i,
   input  wire logic                            pwrite_i,
   input  wire logic [31:0]                     pwdata_i,
   output logic      [31:0]                     prdata_o,
   output logic                                 pready_o,
   output logic                                 pslverr_o,
   input  wire logic                            host_mode_i,
   input  wire logic [utlc_pkg::NUM_TX_EP-1:0][utlc_pkg::MAXP_W-1:0]
                                                tx_fifo_level_i,
   input  wire logic [utlc_pkg::NUM_TX_EP-1:0]  tx_fifo_empty_i,
   input  wire logic [utlc_pkg::NUM_TX_EP-1:0]  tx_sent_i,
   input  wire logic [utlc_pkg::NUM_TX_EP-1:0]  tx_ack_i,
   output logic      [utlc_pkg::NUM_TX_EP-1:0]  tx_pkt_ready_o,
   output logic      [utlc_pkg::NUM_TX_EP-1:0]  tx_toggle_o,
   output logic      [utlc_pkg::NUM_TX_EP-1:0]  fifo_clear_o,
   output logic      [utlc_pkg::NUM_TX_EP-1:0]  iso_o,
   output logic      [utlc_pkg::NUM_TX_EP-1:0]  dir_tx_o,
   output logic      [utlc_pkg::NUM_TX_EP-1:0]  dma_req_o,
   output logic      [utlc_pkg::NUM_TX_EP-1:0]  dma_mode_o,
   input  wire logic                            lpm_token_i,
   input  wire logic [3:0]                      lpm_token_ep_i,
   input  wire logic                            lpm_token_rx_i,
   input  wire logic                            lpm_timeout_i,
   input  wire logic                            bus_resume_i,
   input  wire logic                            resume_start_i,
   output logic                                 lpm_ack_o,
   output logic                                 lpm_nyet_o,
   output logic                                 lpm_event_o,
   output logic                                 lpm_send_o,
   output logic                                 l1_state_o,
   output logic                                 remote_wake_o,
   output logic                                 resume_drive_o
);
   import utlc_pkg::*;

   utlc_state_t            st;
   utlc_state_t            next_st;
   logic [31:0]            rd_word;
   logic                   rd_hit;
   logic                   wr_acc;
   logic                   idx_ok;
   logic [IDX_W-1:0]       sel;
   logic                   all_empty;
   logic [RES_W-1:0]       res_load;

   // Index 0 is endpoint zero, which this window does not serve.
   assign idx_ok    = st.index != '0;
   assign sel       = IDX_W'(st.index - 3'h1);
   assign wr_acc    = psel_i && penable_i && pwrite_i;
   assign all_empty = &tx_fifo_empty_i;
   assign res_load  = RES_W'(RESUME_BASE_CYC)
                    + RES_W'(st.host_resume_duration) * RES_W'(RESUME_STEP_CYC);

   // Read data is captured in the setup cycle so the access phase never
   // needs a wait state and prdata_o still comes from a flip-flop.
   always_comb begin
      rd_word = '0;
      rd_hit  = 1'h1;
      if (paddr_i == REG_INDEX) begin
         rd_word[IDX_W-1:0] = st.index;
      end else if (paddr_i == REG_EP_CTRL) begin
         if (idx_ok) begin
            rd_word[B_AUTO]   = st.auto_set[sel];
            rd_word[B_ISO]    = st.iso[sel] && !host_mode_i;
            rd_word[B_DIR]    = st.dir_tx[sel];
            rd_word[B_DMAEN]  = st.dma_en[sel];
            rd_word[B_FRC]    = st.frc[sel];
            rd_word[B_DMAMD]  = st.dma_md[sel];
            rd_word[B_TOG]    = st.tog[sel];
            rd_word[B_FIFO_NOT_EMPTY] = !tx_fifo_empty_i[sel];
            rd_word[B_PKTRDY] = st.pktrdy[sel];
            rd_word[MULT_LSB +: MULT_W] = st.mult[sel];
            rd_word[MAXP_LSB +: MAXP_W] = st.maxp[sel];
         end
      end else if (paddr_i == REG_LPM) begin
         rd_word[B_L1ST]  = st.l1_state;
         rd_word[B_NYETF] = st.nyet_f;
         rd_word[B_ACKF]  = st.ack_f;
         rd_word[LPM_ENABLE_FIELD_LSB +: 2] = st.lpm_en;
         rd_word[B_L1REQ] = st.l1_req;
         rd_word[LPMEP_LSB +: 4] = st.lpm_ep;
         rd_word[B_RWAKE] = st.rwake;
         rd_word[HOST_RESUME_DURATION_LSB +: 4] = st.host_resume_duration;
      end else begin
         rd_hit = 1'h0;
      end
   end

   always_comb begin
      logic tx_done;
      tx_done  = 1'h0;
      next_st  = st;
      next_st.fifo_clr = '0;
      next_st.lpm_ack  = 1'h0;
      next_st.lpm_nyet = 1'h0;
      next_st.lpm_evt  = 1'h0;
      next_st.lpm_send = 1'h0;

      if (psel_i && !penable_i) begin
         next_st.prdata  = rd_word;
         next_st.pslverr = !rd_hit;
      end

      // Per endpoint packet completion and automatic ready setting.
      for (int e = 0; e < NUM_TX_EP; e++) begin
         tx_done = st.frc[e] ? tx_sent_i[e] : tx_ack_i[e];
         if (st.pktrdy[e] && tx_done) begin
            next_st.pktrdy[e]   = 1'h0;
            next_st.tog[e]      = !st.tog[e];
            next_st.fifo_clr[e] = 1'h1;
         end else if (st.auto_set[e] && !st.pktrdy[e] &&
                      st.maxp[e] != '0 &&
                      tx_fifo_level_i[e] >= st.maxp[e]) begin
            next_st.pktrdy[e] = 1'h1;
         end
      end

      if (wr_acc && paddr_i == REG_INDEX) begin
         next_st.index = pwdata_i[IDX_W-1:0];
      end

      if (wr_acc && paddr_i == REG_EP_CTRL && idx_ok) begin
         next_st.auto_set[sel] = pwdata_i[B_AUTO];
         next_st.iso[sel]      = pwdata_i[B_ISO];
         next_st.dir_tx[sel]   = pwdata_i[B_DIR];
         next_st.dma_en[sel]   = pwdata_i[B_DMAEN];
         next_st.frc[sel]      = pwdata_i[B_FRC];
         next_st.dma_md[sel]   = pwdata_i[B_DMAMD];
         next_st.mult[sel]     = pwdata_i[MULT_LSB +: MULT_W];
         next_st.maxp[sel]     = pwdata_i[MAXP_LSB +: MAXP_W];
         // A written toggle value without the enable bit is dropped.
         if (host_mode_i && pwdata_i[B_WEN]) begin
            next_st.tog[sel] = pwdata_i[B_TOG];
         end
         if (pwdata_i[B_CLRTOG]) begin
            next_st.tog[sel] = 1'h0;
         end
         // Software may only set the ready flag; hardware clears it.
         if (pwdata_i[B_PKTRDY]) begin
            next_st.pktrdy[sel] = 1'h1;
         end
      end

      if (wr_acc && paddr_i == REG_LPM) begin
         next_st.l1_req = pwdata_i[B_L1REQ];
         next_st.lpm_en = pwdata_i[LPM_ENABLE_FIELD_LSB +: 2];
         next_st.lpm_ep = pwdata_i[LPMEP_LSB +: 4];
         next_st.rwake  = pwdata_i[B_RWAKE];
         next_st.host_resume_duration   = pwdata_i[HOST_RESUME_DURATION_LSB +: 4];
         if (pwdata_i[B_ACKF]) begin
            next_st.ack_f = 1'h0;
         end
         if (pwdata_i[B_NYETF]) begin
            next_st.nyet_f = 1'h0;
         end
         if (host_mode_i && pwdata_i[B_L1REQ] && !st.l1_req) begin
            next_st.lpm_send = 1'h1;
            next_st.tmo_cnt  = '0;
         end
      end

      if (host_mode_i) begin
         if (st.l1_req && lpm_token_rx_i) begin
            next_st.l1_req = 1'h0;
         end else if (st.l1_req && lpm_timeout_i) begin
            if (st.tmo_cnt == TMO_LAST) begin
               next_st.l1_req = 1'h0;
            end else begin
               next_st.tmo_cnt = 2'(st.tmo_cnt + 2'h1);
            end
         end
         if (resume_start_i && st.res_cnt == '0) begin
            next_st.res_cnt = res_load;
         end
      end else if (lpm_token_i) begin
         next_st.lpm_ep = lpm_token_ep_i;
         if (st.l1_req && st.lpm_en == LPM_ENABLE_FIELD_L1) begin
            next_st.lpm_evt = 1'h1;
            if (all_empty) begin
               next_st.lpm_ack  = 1'h1;
               next_st.ack_f    = 1'h1;
               next_st.l1_req   = 1'h0;
               next_st.l1_state = 1'h1;
            end else begin
               next_st.lpm_nyet = 1'h1;
               next_st.nyet_f   = 1'h1;
            end
         end
      end

      if (st.res_cnt != '0) begin
         next_st.res_cnt = RES_W'(st.res_cnt - 14'h0001);
      end

      // Leaving suspend drops the one-shot remote wake permission.
      if (bus_resume_i && st.l1_state) begin
         next_st.l1_state = 1'h0;
         next_st.rwake    = 1'h0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign prdata_o       = st.prdata;
   assign pready_o       = 1'h1;
   assign pslverr_o      = psel_i && penable_i && st.pslverr;
   assign tx_pkt_ready_o = st.pktrdy;
   assign tx_toggle_o    = st.tog;
   assign fifo_clear_o   = st.fifo_clr;
   assign iso_o          = host_mode_i ? '0 : st.iso;
   assign dir_tx_o       = st.dir_tx;
   assign dma_mode_o     = st.dma_md;
   // Mode 0 asks for a whole packet once the FIFO has drained; mode 1
   // keeps asking while no packet is waiting to go out.
   assign dma_req_o      = st.dma_en &
                           (( st.dma_md & ~st.pktrdy) |
                            (~st.dma_md & tx_fifo_empty_i));
   assign lpm_ack_o      = st.lpm_ack;
   assign lpm_nyet_o     = st.lpm_nyet;
   assign lpm_event_o    = st.lpm_evt;
   assign lpm_send_o     = st.lpm_send;
   assign l1_state_o     = st.l1_state;
   assign remote_wake_o  = st.rwake && st.l1_state;
   assign resume_drive_o = st.res_cnt != '0;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_lpm_armed;
      !host_mode_i && lpm_token_i && st.l1_req && st.lpm_en == LPM_ENABLE_FIELD_L1;
   endsequence

   sequence s_ack_done;
      lpm_ack_o && lpm_event_o && !st.l1_req && l1_state_o;
   endsequence

   genvar g;
   generate
      for (g = 0; g < NUM_TX_EP; g++) begin : g_ep_chk
         a_dma_req_gate: assert property (
            !st.dma_en[g] |-> !dma_req_o[g])
            else $error("DMA request raised while disabled");
         a_forced_advance: assert property (
            st.frc[g] && st.pktrdy[g] && tx_sent_i[g] && !wr_acc
            |=> fifo_clear_o[g] && tx_toggle_o[g] != $past(st.tog[g]))
            else $error("Forced toggle advance did not happen");
         a_auto_ready_set: assert property (
            st.auto_set[g] && !st.pktrdy[g] && st.maxp[g] != '0 &&
            tx_fifo_level_i[g] >= st.maxp[g] && !wr_acc
            |=> tx_pkt_ready_o[g])
            else $error("Ready flag not set on full packet");
      end
   endgenerate

   a_iso_host_zero: assert property (
      host_mode_i |-> iso_o == '0)
      else $error("Isochronous select active in host mode");

   // The read path is checked apart from the output gate, since software
   // sees the stored bit through a different mux.
   a_iso_read_zero: assert property (
      host_mode_i && psel_i && !penable_i && paddr_i == REG_EP_CTRL
      |=> !prdata_o[B_ISO])
      else $error("Isochronous bit read back in host mode");

   a_toggle_write: assert property (
      host_mode_i && wr_acc && paddr_i == REG_EP_CTRL && idx_ok &&
      pwdata_i[B_WEN] && !pwdata_i[B_CLRTOG]
      |=> tx_toggle_o[$past(sel)] == $past(pwdata_i[B_TOG]))
      else $error("Toggle write with enable was lost");

   a_toggle_read: assert property (
      psel_i && !penable_i && paddr_i == REG_EP_CTRL && idx_ok
      |=> prdata_o[B_TOG] == $past(st.tog[sel]))
      else $error("Toggle read does not show the endpoint toggle");

   a_toggle_locked: assert property (
      wr_acc && paddr_i == REG_EP_CTRL && !pwdata_i[B_WEN] &&
      !pwdata_i[B_CLRTOG] && idx_ok && tx_sent_i == '0 &&
      tx_ack_i == '0 |=> $stable(st.tog))
      else $error("Toggle changed without write enable");

   a_lpm_ack_path: assert property (
      s_lpm_armed ##0 all_empty |=> s_ack_done)
      else $error("LPM ACK path wrong");

   a_lpm_nyet_path: assert property (
      s_lpm_armed ##0 !all_empty
      |=> lpm_nyet_o && lpm_event_o && st.l1_req && !lpm_ack_o)
      else $error("LPM NYET path wrong");

   a_host_lpm_send: assert property (
      host_mode_i && wr_acc && paddr_i == REG_LPM &&
      pwdata_i[B_L1REQ] && !st.l1_req |=> lpm_send_o ##1 !lpm_send_o)
      else $error("Host LPM send pulse missing");

   a_resume_length: assert property (
      host_mode_i && resume_start_i && !resume_drive_o && !wr_acc
      |=> st.res_cnt == res_load && resume_drive_o)
      else $error("Resume count not loaded correctly");

   a_lpm_ep_capture: assert property (
      !host_mode_i && lpm_token_i |=> st.lpm_ep == $past(lpm_token_ep_i))
      else $error("LPM endpoint field not captured");

   a_host_tmo_clear: assert property (
      host_mode_i && st.l1_req && lpm_timeout_i &&
      st.tmo_cnt == TMO_LAST && !wr_acc |=> !st.l1_req)
      else $error("L1 request kept after third timeout");

   a_wake_drop: assert property (
      bus_resume_i && l1_state_o |=> !l1_state_o && !remote_wake_o)
      else $error("Remote wake kept after leaving L1");
endmodule : utlc_ctrl

/* verification/utlc_far_model.sv */
// Far-side model: packet engine, FIFO status and USB bus events.
// Assumes the bench calls its tasks; every task returns 1 ns past an edge.
`timescale 1ns/1ps
module utlc_far_model
   import utlc_pkg::*;
(
   input  wire logic                                        clk_i,
   output logic [utlc_pkg::NUM_TX_EP-1:0][utlc_pkg::MAXP_W-1:0] level_o,
   output logic [utlc_pkg::NUM_TX_EP-1:0]                   empty_o,
   output logic [utlc_pkg::NUM_TX_EP-1:0]                   sent_o,
   output logic [utlc_pkg::NUM_TX_EP-1:0]                   ack_o,
   output logic                                             tok_o,
   output logic [3:0]                                       tok_ep_o,
   output logic                                             tok_rx_o,
   output logic                                             tmo_o,
   output logic                                             resume_o,
   output logic                                             rstart_o
);
   initial begin
      level_o  = '0;
      empty_o  = '1;
      sent_o   = '0;
      ack_o    = '0;
      tok_o    = 1'b0;
      tok_ep_o = 4'hA;
      tok_rx_o = 1'b0;
      tmo_o    = 1'b0;
      resume_o = 1'b0;
      rstart_o = 1'b0;
   end

   task automatic load(input int ep, input logic [MAXP_W-1:0] lv);
      @(posedge clk_i);
      level_o[ep] <= lv;
      empty_o[ep] <= (lv == '0);
      #1;
   endtask : load

   // The answer may come at once or after dly idle cycles.
   task automatic pulse(input int kind, input int ep, input int dly);
      repeat (dly) @(posedge clk_i);
      @(posedge clk_i);
      case (kind)
         0: sent_o[ep] <= 1'b1;
         1: ack_o[ep] <= 1'b1;
         2: begin
            tok_o    <= 1'b1;
            tok_ep_o <= ep[3:0];
         end
         3: tok_rx_o <= 1'b1;
         4: tmo_o <= 1'b1;
         5: resume_o <= 1'b1;
         default: rstart_o <= 1'b1;
      endcase
      @(posedge clk_i);
      sent_o   <= '0;
      ack_o    <= '0;
      tok_o    <= 1'b0;
      tok_rx_o <= 1'b0;
      tmo_o    <= 1'b0;
      resume_o <= 1'b0;
      rstart_o <= 1'b0;
      // A released field must not keep showing the last endpoint.
      tok_ep_o <= ~tok_ep_o;
      #1;
   endtask : pulse
endmodule : utlc_far_model

/* verification/utlc_ctrl_tb_top.sv */
// Self-checking bench for utlc_ctrl driven over APB and by the far model.
// Assumes utlc_pkg, utlc_ctrl and utlc_far_model are compiled first.
`timescale 1ns/1ps
module utlc_ctrl_tb_top;
   import utlc_pkg::*;
   localparam int BASE = 2;
   localparam int STEP = 3;
   logic                 clk_i = 1'b0;
   logic                 rst_n_i = 1'b0;
   logic                 psel = 1'b0;
   logic                 penable = 1'b0;
   logic                 pwrite = 1'b0;
   logic                 host = 1'b0;
   logic [ADDR_W-1:0]    paddr = '0;
   logic [31:0]          pwdata = '0;
   logic [31:0]          prdata, rd, w;
   logic                 pready, pslverr, err;
   logic [NUM_TX_EP-1:0][MAXP_W-1:0] lvl;
   logic [NUM_TX_EP-1:0] empty, sent, ack, pkt, tog, clr, iso, dir, dreq, dmd;
   logic                 tok, tok_rx, tmo, bres, rstart, lack, lnyet, levt;
   logic                 lsend, l1, rwk, rdrv;
   logic [3:0]           tok_ep;
   int                   miscompares = 0;
   int                   tests_run = 0;
   int                   e, n;

   always #50 clk_i = ~clk_i;

   utlc_ctrl #(.RESUME_BASE_CYC(BASE), .RESUME_STEP_CYC(STEP)) i_dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .paddr_i(paddr), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .host_mode_i(host), .tx_fifo_level_i(lvl), .tx_fifo_empty_i(empty),
      .tx_sent_i(sent), .tx_ack_i(ack), .tx_pkt_ready_o(pkt),
      .tx_toggle_o(tog), .fifo_clear_o(clr), .iso_o(iso), .dir_tx_o(dir),
      .dma_req_o(dreq), .dma_mode_o(dmd), .lpm_token_i(tok),
      .lpm_token_ep_i(tok_ep), .lpm_token_rx_i(tok_rx),
      .lpm_timeout_i(tmo), .bus_resume_i(bres), .resume_start_i(rstart),
      .lpm_ack_o(lack), .lpm_nyet_o(lnyet), .lpm_event_o(levt),
      .lpm_send_o(lsend), .l1_state_o(l1), .remote_wake_o(rwk),
      .resume_drive_o(rdrv));

   utlc_far_model i_far (
      .clk_i(clk_i), .level_o(lvl), .empty_o(empty), .sent_o(sent),
      .ack_o(ack), .tok_o(tok), .tok_ep_o(tok_ep), .tok_rx_o(tok_rx),
      .tmo_o(tmo), .resume_o(bres), .rstart_o(rstart));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results

   task automatic done(input string s);
      $display("test %s done, mismatches %0d", s, miscompares);
   endtask : done

   // Request held until pready is seen high at a rising edge.
   task automatic apb(input logic [ADDR_W-1:0] a, input logic wr,
                      input logic [31:0] d);
      int k;
      @(posedge clk_i);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clk_i);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         miscompares++;
         results();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb

   task automatic epw(input int ep, input logic [31:0] d);
      apb(REG_INDEX, 1'b1, ep);
      apb(REG_EP_CTRL, 1'b1, d);
   endtask : epw

   task automatic set_host(input logic v);
      @(posedge clk_i);
      host <= v;
      #1;
   endtask : set_host

   function automatic logic [31:0] exp_ctrl(input logic [31:0] wd,
      input logic hm, input logic tg, input logic rdy, input logic ne);
      logic [31:0] r;
      r = wd & 32'hFC00_FFFF;
      r[30] = r[30] & ~hm;
      r[24] = tg;
      r[17] = ne;
      r[16] = rdy;
      return r;
   endfunction : exp_ctrl

   function automatic int res_cyc(input int h);
      return BASE + STEP * h;
   endfunction : res_cyc

   initial begin
      void'($urandom(39484));
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      apb(12'h0FC, 1'b0, '0);
      check(err, 1'b1);
      epw(0, 32'hFFFF_FFFF);
      apb(REG_EP_CTRL, 1'b0, '0);
      check(rd, 32'h0000_0000);
      for (e = 1; e <= NUM_TX_EP; e++) begin
         set_host(e[0]);
         w = ($urandom() & 32'hFC00_FFFF) | 32'h0000_0400;
         epw(e, w);
         apb(REG_EP_CTRL, 1'b0, '0);
         check(rd, exp_ctrl(w, e[0], 1'b0, 1'b0, 1'b0));
         check(iso[e-1], w[30] & ~e[0]);
         check(dir[e-1], w[29]);
         check(dreq[e-1], w[28]);
         check(dmd[e-1], w[26]);
         epw(e, w & 32'hEFFF_FFFF);
      end
      done("fields");
      set_host(1'b0);
      epw(3, 32'h8000_0040);
      i_far.load(2, 11'd63);
      repeat (3) @(posedge clk_i);
      #1 check(pkt[2], 1'b0);
      i_far.load(2, 11'd64);
      repeat (3) @(posedge clk_i);
      #1 check(pkt[2], 1'b1);
      epw(3, 32'h1400_0040);
      check(dreq[2], 1'b0);
      apb(REG_EP_CTRL, 1'b0, '0);
      check(rd, exp_ctrl(32'h1400_0040, 0, 0, 1, 1));
      i_far.pulse(0, 2, 0);
      check({clr[2], pkt[2]}, 2'b01);
      i_far.pulse(1, 2, 2);
      check({clr[2], tog[2], pkt[2], dreq[2]}, 4'b1101);
      epw(3, 32'h0400_0040);
      check(dreq[2], 1'b0);
      epw(3, 32'h0801_0040);
      i_far.pulse(0, 2, 0);
      check({clr[2], tog[2], pkt[2]}, 3'b100);
      i_far.load(2, 11'd0);
      epw(3, 32'h1000_0040);
      check(dreq[2], 1'b1);
      done("transmit");
      set_host(1'b1);
      epw(4, 32'h0100_0040);
      check(tog[3], 1'b0);
      epw(4, 32'h0300_0040);
      apb(REG_EP_CTRL, 1'b0, '0);
      check({tog[3], rd[25:24]}, 3'b101);
      set_host(1'b0);
      epw(4, 32'h0200_0040);
      check(tog[3], 1'b1);
      epw(4, 32'h0040_0040);
      apb(REG_EP_CTRL, 1'b0, '0);
      check({tog[3], rd[24], rd[22]}, 3'b000);
      done("toggle");
      i_far.pulse(2, 7, 0);
      check({lack, lnyet, levt}, 3'b000);
      apb(REG_LPM, 1'b1, 32'h0007_0100);
      i_far.load(0, 11'd8);
      i_far.pulse(2, 5, 1);
      check({lack, lnyet, levt, l1}, 4'b0110);
      apb(REG_LPM, 1'b0, '0);
      check({rd[21:20], rd[16:12]}, 7'h55);
      i_far.load(0, 11'd0);
      e = $urandom_range(15, 0);
      i_far.pulse(2, e, 0);
      check({lack, lnyet, levt, l1, rwk}, 5'b10111);
      apb(REG_LPM, 1'b0, '0);
      check({rd[22:20], rd[16:12]}, {4'hE, e[3:0]});
      i_far.pulse(5, 0, 0);
      apb(REG_LPM, 1'b0, '0);
      check({l1, rwk, rd[8]}, 3'b000);
      done("lpm device");
      set_host(1'b1);
      apb(REG_LPM, 1'b1, 32'h0031_0000);
      n = 0;
      repeat (3) begin
         if (lsend === 1'b1) n++;
         @(posedge clk_i);
         #1;
      end
      check(n, 1);
      i_far.pulse(4, 0, 0);
      i_far.pulse(4, 0, 3);
      apb(REG_LPM, 1'b0, '0);
      check({rd[21:20], rd[16]}, 3'b001);
      i_far.pulse(4, 0, 0);
      apb(REG_LPM, 1'b0, '0);
      check(rd[16], 1'b0);
      apb(REG_LPM, 1'b1, 32'h0001_0000);
      i_far.pulse(3, 0, 1);
      apb(REG_LPM, 1'b0, '0);
      check(rd[16], 1'b0);
      done("lpm host");
      for (e = 0; e < 16; e++) begin
         apb(REG_LPM, 1'b1, e << 4);
         i_far.pulse(6, 0, 0);
         n = 0;
         repeat (60) begin
            if (rdrv === 1'b1) n++;
            @(posedge clk_i);
            #1;
         end
         check(n, res_cyc(e));
      end
      done("resume");
      results();
   end
endmodule : utlc_ctrl_tb_top
